// ### logic/sio_pkg.sv
package sio_pkg;
    // ****************************************
    // Function codes
    // ****************************************
    localparam logic [7:0] FC_RD1     = 8'h03;
    localparam logic [7:0] FC_WR1     = 8'h10;
    localparam logic [7:0] FC_RD2     = 8'h43;
    localparam logic [7:0] FC_WR2     = 8'h50;
    localparam logic [7:0] FC_FAIL    = 8'h80;
    // ****************************************
    // Fault codes
    // ****************************************
    localparam logic [7:0] FLT_FUNC   = 8'h01;
    localparam logic [7:0] FLT_REG    = 8'h02;
    localparam logic [7:0] FLT_SLAVE  = 8'h04;
    localparam logic [7:0] FLT_RANGE  = 8'h21;
    localparam logic [7:0] FLT_MODE   = 8'h22;
    localparam logic [7:0] FLT_SIZE   = 8'h23;
    // ****************************************
    // Record layout, reset values and response timeout
    // ****************************************
    localparam int         REC_BYTES  = 8;
    localparam int         B_FC       = 0;
    localparam int         B_RN_LO    = 2;
    localparam int         B_RN_HI    = 3;
    localparam int         B_W0_LO    = 4;
    localparam int         B_W0_HI    = 5;
    localparam int         B_W1_LO    = 6;
    localparam int         B_W1_HI    = 7;
    localparam logic [63:0] REC_RST   = 64'h0;
    localparam int         RESP_TMO   = 255;
endpackage

// ### logic/sio_req_capture.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Request record change detector
// ****************************************
module sio_req_capture (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [63:0] rec_in,
    input  wire logic        take,
    output logic [63:0]      rec_r,
    output logic             changed
);
    logic [63:0] rec_nxt;
    logic [63:0] last_r;
    logic [63:0] last_nxt;

    always_comb begin
        rec_nxt  = rec_in;
        last_nxt = take ? rec_r : last_r;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rec_r  <= sio_pkg::REC_RST;
            last_r <= sio_pkg::REC_RST;
        end else begin
            rec_r  <= rec_nxt;
            last_r <= last_nxt;
        end
    end

    assign changed = (rec_r != last_r);
endmodule
`default_nettype wire

// ### logic/sio_access.sv
// Functional notes
// - The register number names one inverter parameter on the serial bus.
// - Byte 0 echoes the code on success, or the code OR 80 hex on failure.
// - Bytes 2 and 3 echo the register number, low first, in every answer.
// - Read data returns word 0 in bytes 4-5 and word 1 in bytes 6-7.
// - An unknown function code gives fault 01 hex.
// - A register number that does not exist gives fault 02 hex.
// - A failed inverter transfer gives fault 04 hex.
// - Write data outside the register's limits gives fault 21 hex.
// - A write refused by the inverter mode gives fault 22 hex.
// - An access of the wrong word size gives fault 23 hex.
`timescale 1ns/10ps
`default_nettype none
module sio_access (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [63:0] req_rec,
    output logic [63:0]      resp_rec,
    output logic             par_req,
    output logic             par_write,
    output logic [15:0]      par_addr,
    output logic [31:0]      par_wdata,
    output logic             par_double,
    input  wire logic        par_ack,
    input  wire logic [31:0] par_rdata,
    input  wire logic        par_exists,
    input  wire logic        par_is_double,
    input  wire logic        par_range_err,
    input  wire logic        par_mode_err,
    input  wire logic        par_comm_err
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] rec_byte(input logic [63:0] r,
                                            input int i);
        rec_byte = r[8*i +: 8];
    endfunction

    function automatic logic fc_valid(input logic [7:0] fc);
        fc_valid = (fc == sio_pkg::FC_RD1) || (fc == sio_pkg::FC_WR1) ||
                   (fc == sio_pkg::FC_RD2) || (fc == sio_pkg::FC_WR2);
    endfunction

    typedef enum logic [1:0] {
        SIO_IDLE = 2'b00,
        SIO_BUSY = 2'b01,
        SIO_DONE = 2'b10
    } sio_state_e;

    sio_state_e  st_r;
    sio_state_e  st_nxt;
    logic [63:0] resp_r;
    logic [63:0] resp_nxt;
    logic [7:0]  tmo_r;
    logic [7:0]  tmo_nxt;
    logic [63:0] req_q;
    logic [63:0] cur_r;
    logic [63:0] cur_nxt;
    logic [63:0] act;
    logic        changed;
    logic        take;
    logic [7:0]  fc;
    logic [15:0] rnum;
    logic        is_wr;
    logic        is_dbl;
    logic [7:0]  flt;
    logic        fail;

    sio_req_capture u_cap (
        .clock   (clock),
        .rst     (rst),
        .rec_in  (req_rec),
        .take    (take),
        .rec_r   (req_q),
        .changed (changed)
    );

    // ****************************************
    // Request decode
    // ****************************************
    // Taken request is held while busy; later changes wait
    assign act    = (st_r == SIO_IDLE) ? req_q : cur_r;
    assign fc     = rec_byte(act, sio_pkg::B_FC);
    assign rnum   = {rec_byte(act, sio_pkg::B_RN_HI),
                     rec_byte(act, sio_pkg::B_RN_LO)};
    assign is_wr  = (fc == sio_pkg::FC_WR1) || (fc == sio_pkg::FC_WR2);
    assign is_dbl = (fc == sio_pkg::FC_RD2) || (fc == sio_pkg::FC_WR2);
    assign take   = (st_r == SIO_IDLE) && changed;

    assign par_req    = (st_r == SIO_BUSY);
    assign par_write  = is_wr;
    assign par_addr   = rnum;
    assign par_wdata  = act[63:32];
    assign par_double = is_dbl;

    // ****************************************
    // Fault priority
    // ****************************************
    always_comb begin
        flt = 8'h00;
        if (!fc_valid(fc)) begin
            flt = sio_pkg::FLT_FUNC;
        end else if (tmo_r == 8'h00 || par_comm_err) begin
            flt = sio_pkg::FLT_SLAVE;
        end else if (!par_exists) begin
            flt = sio_pkg::FLT_REG;
        end else if (par_is_double != is_dbl) begin
            flt = sio_pkg::FLT_SIZE;
        end else if (is_wr && par_range_err) begin
            flt = sio_pkg::FLT_RANGE;
        end else if (is_wr && par_mode_err) begin
            flt = sio_pkg::FLT_MODE;
        end
    end
    assign fail = (flt != 8'h00);

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        st_nxt   = st_r;
        resp_nxt = resp_r;
        tmo_nxt  = tmo_r;
        cur_nxt  = cur_r;
        unique case (st_r)
            SIO_IDLE: begin
                tmo_nxt = 8'(sio_pkg::RESP_TMO);
                if (take) begin
                    cur_nxt = req_q;
                    st_nxt = fc_valid(fc) ? SIO_BUSY : SIO_DONE;
                end
            end
            SIO_BUSY: begin
                if (tmo_r != 8'h00) begin
                    tmo_nxt = tmo_r - 8'h01;
                end
                if (par_ack || tmo_r == 8'h00) begin
                    st_nxt = SIO_DONE;
                end
            end
            SIO_DONE: begin
                st_nxt = SIO_IDLE;
            end
            default: begin
                st_nxt = SIO_IDLE;
            end
        endcase
        if (st_nxt == SIO_DONE) begin
            resp_nxt = 64'h0;
            resp_nxt[15:8]  = 8'h00;
            resp_nxt[31:16] = rnum;
            if (fail) begin
                resp_nxt[7:0]   = fc | sio_pkg::FC_FAIL;
                resp_nxt[39:32] = flt;
            end else begin
                resp_nxt[7:0] = fc;
                if (!is_wr) begin
                    resp_nxt[47:32] = par_rdata[15:0];
                    resp_nxt[63:48] = is_dbl ? par_rdata[31:16] : 16'h0;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_r   <= SIO_IDLE;
            resp_r <= sio_pkg::REC_RST;
            tmo_r  <= 8'h00;
            cur_r  <= sio_pkg::REC_RST;
        end else begin
            st_r   <= st_nxt;
            resp_r <= resp_nxt;
            tmo_r  <= tmo_nxt;
            cur_r  <= cur_nxt;
        end
    end
    assign resp_rec = resp_r;

    // ****************************************
    // Checks
    // ****************************************
    property p_bad_fc;
        @(posedge clock) disable iff (rst)
        take && !fc_valid(fc) |=> ##1 (resp_rec[7:0] == ($past(fc, 2) | 8'h80)
            && resp_rec[39:32] == 8'h01);
    endproperty
    a_bad_fc: assert property (p_bad_fc) else $error("bad code");

    property p_echo;
        @(posedge clock) disable iff (rst)
        st_r == SIO_DONE |-> resp_rec[31:16] == $past(rnum);
    endproperty
    a_echo: assert property (p_echo) else $error("no echo");

    property p_start;
        @(posedge clock) disable iff (rst)
        take && fc_valid(fc) |=> par_req;
    endproperty
    a_start: assert property (p_start) else $error("no start");

    property p_rd;
        @(posedge clock) disable iff (rst)
        par_req && par_ack && !fail && !is_wr |=>
            resp_rec[47:32] == $past(par_rdata[15:0]);
    endproperty
    a_rd: assert property (p_rd) else $error("bad read");

    property p_ok;
        @(posedge clock) disable iff (rst)
        par_req && par_ack && !fail |=> resp_rec[7:0] == $past(fc);
    endproperty
    a_ok: assert property (p_ok) else $error("bad echo");

    property p_size;
        @(posedge clock) disable iff (rst)
        par_req && par_ack && fc_valid(fc) && par_exists && !par_comm_err
            && par_is_double != is_dbl && tmo_r != 8'h00
            |=> resp_rec[39:32] == 8'h23;
    endproperty
    a_size: assert property (p_size) else $error("size");

    property p_reg;
        @(posedge clock) disable iff (rst)
        par_req && par_ack && fc_valid(fc) && !par_exists && !par_comm_err
            && tmo_r != 8'h00 |=> resp_rec[39:32] == 8'h02;
    endproperty
    a_reg: assert property (p_reg) else $error("reg");

    property p_comm;
        @(posedge clock) disable iff (rst)
        par_req && par_ack && par_comm_err |=> resp_rec[39:32] == 8'h04;
    endproperty
    a_comm: assert property (p_comm) else $error("comm");
endmodule
`default_nettype wire

// ### tb/sio_inv_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Inverter parameter side
// ****************************************
module sio_inv_model (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        par_req,
    input  wire logic        par_write,
    input  wire logic [15:0] par_addr,
    input  wire logic [31:0] par_wdata,
    input  wire logic        par_double,
    input  wire logic [7:0]  slow,
    input  wire logic        comm_bad,
    output logic             par_ack,
    output logic [31:0]      par_rdata,
    output logic             par_exists,
    output logic             par_is_double,
    output logic             par_range_err,
    output logic             par_mode_err,
    output logic             par_comm_err
);
    logic [31:0] mem [8];
    logic [7:0]  wait_r;
    logic        hit;
    assign hit = (par_addr & 16'hfff8) == 16'h1200;
    always @(posedge clock) begin
        par_ack   <= 1'b0;
        par_rdata <= ~par_rdata;
        if (rst) begin
            wait_r <= 8'h00;
            for (int i = 0; i < 8; i++) mem[i] <= 32'h0;
        end else if (par_req && !par_ack) begin
            wait_r <= wait_r + 8'h01;
            if (wait_r == slow && slow != 8'hff) begin
                wait_r        <= 8'h00;
                par_ack       <= 1'b1;
                par_rdata     <= mem[par_addr[2:0]];
                par_exists    <= hit;
                par_is_double <= par_addr[0];
                par_range_err <= par_wdata[15];
                par_mode_err  <= par_addr == 16'h1206;
                par_comm_err  <= comm_bad;
                if (par_write && hit && !comm_bad && !par_wdata[15])
                    mem[par_addr[2:0]] <= par_double ? par_wdata
                                          : {16'h0, par_wdata[15:0]};
            end
        end else if (!par_req) begin
            wait_r <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// ### tb/tb_sio_access.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Bench
// ****************************************
module tb_sio_access;
    localparam logic [7:0]  R1 = sio_pkg::FC_RD1;
    localparam logic [7:0]  W1 = sio_pkg::FC_WR1;
    localparam logic [7:0]  R2 = sio_pkg::FC_RD2;
    localparam logic [7:0]  W2 = sio_pkg::FC_WR2;
    localparam logic [15:0] A2 = 16'h1202;
    localparam logic [15:0] A3 = 16'h1203;
    localparam logic [15:0] AN = 16'h0202;
    localparam logic [15:0] AM = 16'h1206;
    localparam logic [31:0] D1 = 32'h1234;
    localparam logic [31:0] DV = 32'h8000;
    localparam logic [63:0] MR = 64'hffff_ffff_ffff_00ff;
    localparam logic [63:0] MW = 64'h0000_0000_ffff_00ff;
    localparam logic [63:0] MF = 64'h0000_00ff_ffff_00ff;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        comm_bad = 1'b0;
    logic [7:0]  slow = 8'h00;
    logic [63:0] req_rec = 64'h0;
    logic [63:0] resp_rec;
    logic [15:0] par_addr;
    logic [31:0] par_wdata, par_rdata;
    logic        par_req, par_write, par_double, par_ack, par_exists;
    logic        par_is_double, par_range_err, par_mode_err, par_comm_err;
    int          num_errors = 0;
    int          compares = 0;
    always #20 clock = ~clock;
    sio_access DUT (.clock(clock), .rst(rst), .req_rec(req_rec),
        .resp_rec(resp_rec), .par_req(par_req), .par_write(par_write),
        .par_addr(par_addr), .par_wdata(par_wdata), .par_double(par_double),
        .par_ack(par_ack), .par_rdata(par_rdata), .par_exists(par_exists),
        .par_is_double(par_is_double), .par_range_err(par_range_err),
        .par_mode_err(par_mode_err), .par_comm_err(par_comm_err));
    sio_inv_model INV (.clock(clock), .rst(rst), .par_req(par_req),
        .par_write(par_write), .par_addr(par_addr), .par_wdata(par_wdata),
        .par_double(par_double), .slow(slow), .comm_bad(comm_bad),
        .par_ack(par_ack), .par_rdata(par_rdata), .par_exists(par_exists),
        .par_is_double(par_is_double), .par_range_err(par_range_err),
        .par_mode_err(par_mode_err), .par_comm_err(par_comm_err));
    task automatic end_sim();
        if (num_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge clock);
        #1;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, g, m);
        compares++;
        if (((g ^ e) & m) !== 64'h0) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e & m, g & m);
        end
    endtask
    function automatic logic [63:0] rq(input logic [7:0] fc,
                                       input logic [15:0] rn,
                                       input logic [31:0] d);
        return {d, rn, 8'h00, fc};
    endfunction
    function automatic logic [63:0] fl(input logic [7:0] fc,
                                       input logic [15:0] rn,
                                       input logic [7:0] code);
        return {24'h0, code, rn, 8'h00, fc | sio_pkg::FC_FAIL};
    endfunction
    task automatic drain(input int k);
        int n;
        n = 0;
        repeat (k) tick();
        while (par_req === 1'b1 && n < 400) begin
            tick();
            n++;
        end
    endtask
    task automatic run(input logic [63:0] req, e, m);
        req_rec = req;
        drain(4);
        chk("resp_rec", e, resp_rec, m);
    endtask
    task automatic t_rw();
        slow = 8'h14;
        run(rq(W1, A2, D1), rq(W1, A2, 0), MW);
        slow = 8'h00;
        run(rq(R1, A2, 0), rq(R1, A2, 32'h1234), MR);
        run(rq(W2, A3, 32'h5678_4321), rq(W2, A3, 0), MW);
        run(rq(R2, A3, 0), rq(R2, A3, 32'h5678_4321), MR);
    endtask
    task automatic t_flt();
        run(rq(8'h07, A2, 0), fl(8'h07, A2, sio_pkg::FLT_FUNC), MF);
        run(rq(R1, AN, 0), fl(R1, AN, sio_pkg::FLT_REG), MF);
        run(rq(R1, A3, 0), fl(R1, A3, sio_pkg::FLT_SIZE), MF);
        run(rq(W1, A2, DV), fl(W1, A2, sio_pkg::FLT_RANGE), MF);
        run(rq(W1, AM, 1), fl(W1, AM, sio_pkg::FLT_MODE), MF);
        comm_bad = 1'b1;
        run(rq(R1, A2, 0), fl(R1, A2, sio_pkg::FLT_SLAVE), MF);
        comm_bad = 1'b0;
        slow = 8'hff;
        run(rq(R2, A3, 0), fl(R2, A3, sio_pkg::FLT_SLAVE), MF);
        slow = 8'h00;
    endtask
    task automatic t_same();
        slow = 8'h1e;
        req_rec = rq(R1, A2, 0);
        repeat (6) tick();
        req_rec = rq(W2, A3, 32'h0000_0042);
        drain(0);
        chk("resp_rec", rq(R1, A2, 32'h1234), resp_rec, MR);
        drain(4);
        chk("resp_rec", rq(W2, A3, 0), resp_rec, MW);
        repeat (6) tick();
        chk("par_req", 64'h0, {63'h0, par_req}, 64'h1);
    endtask
    task automatic t_rst();
        req_rec = rq(R1, A2, 0);
        repeat (4) tick();
        rst = 1'b1;
        repeat (2) tick();
        chk("resp_rec", 64'h0, resp_rec, 64'hffff_ffff_ffff_ffff);
        chk("par_req", 64'h0, {63'h0, par_req}, 64'h1);
        rst = 1'b0;
        drain(4);
        chk("resp_rec", rq(R1, A2, 0), resp_rec, MR);
    endtask
    initial begin
        repeat (20) tick();
        rst = 1'b0;
        t_rw();
        t_flt();
        t_same();
        t_rst();
        end_sim();
    end
    initial begin
        repeat (5000) @(posedge clock);
        num_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
